// *** aoed_defs.svh ***
// Constants for the accumulator datapath and exponent detector.
// Assumes inclusion by bare name from the package and design files.
`ifndef AOED_DEFS_SVH
`define AOED_DEFS_SVH

// Accumulator geometry
`define AOED_ACC_W 40
`define AOED_WORD_W 16
`define AOED_BYTE_W 8
`define AOED_GUARD_W 8
`define AOED_LOW_MSB 15
`define AOED_LOW_LSB 0
`define AOED_HIGH_MSB 31
`define AOED_HIGH_LSB 16
`define AOED_GUARD_MSB 39
`define AOED_GUARD_LSB 32
`define AOED_SIGN31_BIT 31

// Reset values
`define AOED_ACC_RST 40'h00_0000_0000
`define AOED_WORD_RST 16'h0000
`define AOED_EXP_RST 6'h00

// Rounding constant: half of one high-word step
`define AOED_ROUND_ADD 40'h00_0000_8000

// Shift amount width, signed
`define AOED_SHIFT_W 6

// Exponent detector scan tops
`define AOED_EXP_TOP_WORD 4'hf
`define AOED_EXP_TOP_BYTE 4'h7

`endif

// *** aoed_pkg.sv ***
// Types shared by the accumulator datapath modules.
// Assumes aoed_defs.svh is on the include path.
`include "aoed_defs.svh"

package aoed_pkg;

  // Datapath operations issued by the instruction decoder
  typedef enum logic [3:0] {
    AOED_OP_NOP       = 4'h0,
    AOED_OP_ADD_ACC   = 4'h1,
    AOED_OP_SUB_ACC   = 4'h2,
    AOED_OP_ADD_W16   = 4'h3,
    AOED_OP_LOAD      = 4'h4,
    AOED_OP_NEGATE    = 4'h5,
    AOED_OP_STORE     = 4'h6,
    AOED_OP_STORE_RND = 4'h7,
    AOED_OP_SHIFT_LIT = 4'h8,
    AOED_OP_SHIFT_REG = 4'h9,
    AOED_OP_EXP_FIND  = 4'ha
  } aoed_op_t;

  // Memory-mapped accumulator parts
  typedef enum logic [1:0] {
    AOED_PART_LOW   = 2'h0,
    AOED_PART_HIGH  = 2'h1,
    AOED_PART_GUARD = 2'h2
  } aoed_part_t;

  typedef logic [`AOED_ACC_W-1:0] aoed_acc_t;

endpackage

// *** aoed_dp_if.sv ***
// Carrier between the datapath top and its shifter and exponent detector.
// Assumes a single core clock; all members are combinational.
`timescale 1ns/10ps
`default_nettype none

`include "aoed_defs.svh"

interface aoed_dp_if;
  // Shifter group
  logic [`AOED_ACC_W-1:0] sh_in;
  logic signed [`AOED_SHIFT_W-1:0] sh_amt;
  logic [`AOED_ACC_W-1:0] sh_out;
  logic sh_lost;
  // Exponent detector group
  logic [`AOED_WORD_W-1:0] ex_operand;
  logic ex_byte;
  logic signed [`AOED_SHIFT_W-1:0] ex_result;

  modport ctrl (output sh_in, sh_amt, ex_operand, ex_byte, input sh_out, sh_lost, ex_result);
  modport shifter (input sh_in, sh_amt, output sh_out, sh_lost);
  modport expdet (input ex_operand, ex_byte, output ex_result);
endinterface

`default_nettype wire

// *** aoed_shifter.sv ***
// 40-bit arithmetic shifter: positive amount shifts right, negative left.
// Assumes the amount magnitude fits the signed shift width.
`timescale 1ns/10ps
`default_nettype none

`include "aoed_defs.svh"

module aoed_shifter (
  // Shift request and result
  aoed_dp_if.shifter dp
);
  logic [`AOED_SHIFT_W-1:0] mag;
  logic [`AOED_ACC_W-1:0] left;

  // Magnitude and left result
  assign mag = dp.sh_amt[`AOED_SHIFT_W-1] ? `AOED_SHIFT_W'(-dp.sh_amt) : dp.sh_amt;
  assign left = dp.sh_in << mag;

  // Right keeps sign, left shifts in zeros
  always_comb begin
    if (dp.sh_amt[`AOED_SHIFT_W-1]) begin
      dp.sh_out = left;
    end else begin
      dp.sh_out = `AOED_ACC_W'($signed(dp.sh_in) >>> mag);
    end
  end

  // Bits lost off the top of a left shift
  assign dp.sh_lost = dp.sh_amt[`AOED_SHIFT_W-1] &&
                      (`AOED_ACC_W'($signed(left) >>> mag) != dp.sh_in);
endmodule

`default_nettype wire

// *** aoed_exp_detect.sv ***
// Exponent detector: negated count of redundant sign bits.
// Assumes byte operands sit in the low eight bits of the operand.
`timescale 1ns/10ps
`default_nettype none

`include "aoed_defs.svh"

module aoed_exp_detect (
  // Operand and result
  aoed_dp_if.expdet dp
);
  logic [3:0] top;
  logic [3:0] mag;
  logic sign;
  logic found;

  // Scan from just below the sign toward bit zero
  always_comb begin
    top = dp.ex_byte ? `AOED_EXP_TOP_BYTE : `AOED_EXP_TOP_WORD;
    sign = dp.ex_byte ? dp.ex_operand[`AOED_BYTE_W-1] : dp.ex_operand[`AOED_WORD_W-1];
    mag = top;
    found = 1'b0;
    for (int i = `AOED_WORD_W - 2; i >= 0; i--) begin
      if (!found && (i < int'(top)) && (dp.ex_operand[i] != sign)) begin
        mag = 4'(int'(top) - 1 - i);
        found = 1'b1;
      end
    end
    dp.ex_result = -$signed({2'b00, mag});
  end
endmodule

`default_nettype wire

// *** aoed_top.sv ***
// Accumulator datapath: two 40-bit accumulators, their arithmetic,
// shifts, loads, stores and the exponent detector.
// Assumes one op per cycle from the decoder, memory data valid with it.
//
// Summary of operation
// - Two 40-bit accumulators, one picked per operation.
// - No memory prefetch and no alternate-accumulator write back.
// - Add, negate, shift, load and store are separate operations.
// - Add and subtract combine both accumulators into the selected one.
// - Signed 16-bit operand is sign-extended and added into an accumulator.
// - Rounded store writes only the 16-bit high word in 1.15 form.
// - Shift amount comes from a literal or a working register.
// - A 40-bit shifter does the shift; negative amount shifts left.
// - Negative count means left, so detector output scales up directly.
// - Detector scans from sign toward bit zero for first differing bit.
// - Detector returns the negated exponent, from minus fifteen to zero.
// - Word detector returns zero when bit fourteen differs from the sign.
// - All-zeros or all-ones word returns minus fifteen.
// - Results match scaling pairs, e.g. 0x0001 gives -14, 0xFF07 gives -7.
// - Each accumulator has eight guard bits in its top byte.
// - Detector takes a byte operand or a word operand.
// - Guard bytes read through the memory map are sign-extended to 16 bits.
// - Status flags change only by datapath ops and clear_sat_i, never by mapped writes.
`timescale 1ns/10ps
`default_nettype none

`include "aoed_defs.svh"

module aoed_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Operation from the decoder
  input wire logic op_valid_i,
  input wire aoed_pkg::aoed_op_t op_i,
  input wire logic acc_sel_i,
  input wire logic [`AOED_SHIFT_W-1:0] lit_shift_i,
  input wire logic [`AOED_WORD_W-1:0] reg_shift_i,
  input wire logic [`AOED_WORD_W-1:0] operand_i,
  input wire logic exp_byte_i,
  // Store and exponent results
  output logic [`AOED_WORD_W-1:0] store_data_o,
  output logic store_valid_o,
  output logic [`AOED_SHIFT_W-1:0] exp_result_o,
  output logic exp_valid_o,
  // Memory-mapped accumulator access
  input wire logic mm_wr_i,
  input wire logic mm_acc_i,
  input wire aoed_pkg::aoed_part_t mm_part_i,
  input wire logic [`AOED_WORD_W-1:0] mm_wdata_i,
  output logic [`AOED_WORD_W-1:0] mm_rdata_o,
  // Status
  input wire logic clear_sat_i,
  output logic accum_a_overflow_flag_o,
  output logic accum_b_overflow_flag_o,
  output logic accum_a_sat_flag_o,
  output logic accum_b_sat_flag_o,
  // Accumulator contents
  output logic [`AOED_ACC_W-1:0] acc_a_o,
  output logic [`AOED_ACC_W-1:0] acc_b_o
);
  import aoed_pkg::*;

  aoed_dp_if dp ();

  aoed_acc_t acc_r [2];
  logic ovf_r [2];
  logic sat_r [2];
  aoed_acc_t sel_acc;
  aoed_acc_t oth_acc;
  aoed_acc_t word_ext;
  aoed_acc_t round_sum;
  logic [`AOED_ACC_W:0] arith;
  aoed_acc_t result_nxt;
  logic write_nxt;
  logic sat_event;
  logic is_shift;

  // Shifter and exponent detector
  aoed_shifter u_shifter (
    .dp(dp.shifter)
  );

  aoed_exp_detect u_exp_detect (
    .dp(dp.expdet)
  );

  // Selected and alternate accumulators
  assign sel_acc = acc_r[acc_sel_i];
  assign oth_acc = acc_r[~acc_sel_i];

  // Memory word sign-extended to the full width
  assign word_ext = {{(`AOED_ACC_W - `AOED_WORD_W){operand_i[`AOED_WORD_W-1]}}, operand_i};

  // Shift amount from literal or working register
  assign is_shift = (op_i == AOED_OP_SHIFT_LIT) || (op_i == AOED_OP_SHIFT_REG);
  assign dp.sh_in = sel_acc;
  assign dp.sh_amt = (op_i == AOED_OP_SHIFT_REG) ?
                     $signed(reg_shift_i[`AOED_SHIFT_W-1:0]) :
                     $signed(lit_shift_i);

  // Exponent detector fed straight from the operand bus
  assign dp.ex_operand = operand_i;
  assign dp.ex_byte = exp_byte_i;

  // Rounded high word source
  assign round_sum = sel_acc + `AOED_ROUND_ADD;

  // Arithmetic on a 41-bit span to catch 40-bit wrap
  always_comb begin
    arith = '0;
    write_nxt = 1'b0;
    sat_event = 1'b0;
    result_nxt = sel_acc;
    if (op_valid_i) begin
      case (op_i)
        AOED_OP_ADD_ACC: begin
          arith = {sel_acc[`AOED_ACC_W-1], sel_acc} + {oth_acc[`AOED_ACC_W-1], oth_acc};
          write_nxt = 1'b1;
        end
        AOED_OP_SUB_ACC: begin
          arith = {sel_acc[`AOED_ACC_W-1], sel_acc} - {oth_acc[`AOED_ACC_W-1], oth_acc};
          write_nxt = 1'b1;
        end
        AOED_OP_ADD_W16: begin
          arith = {sel_acc[`AOED_ACC_W-1], sel_acc} + {word_ext[`AOED_ACC_W-1], word_ext};
          write_nxt = 1'b1;
        end
        AOED_OP_NEGATE: begin
          arith = {(`AOED_ACC_W + 1){1'b0}} - {sel_acc[`AOED_ACC_W-1], sel_acc};
          write_nxt = 1'b1;
        end
        AOED_OP_LOAD: begin
          // Word lands in the high word, guard sign-filled, low cleared
          arith = {{(`AOED_GUARD_W + 1){operand_i[`AOED_WORD_W-1]}}, operand_i,
                   `AOED_WORD_RST};
          write_nxt = 1'b1;
        end
        AOED_OP_SHIFT_LIT, AOED_OP_SHIFT_REG: begin
          arith = {dp.sh_out[`AOED_ACC_W-1], dp.sh_out};
          write_nxt = 1'b1;
        end
        default: begin
          arith = {sel_acc[`AOED_ACC_W-1], sel_acc};
          write_nxt = 1'b0;
        end
      endcase
      result_nxt = arith[`AOED_ACC_W-1:0];
      sat_event = write_nxt && ((arith[`AOED_ACC_W] != arith[`AOED_ACC_W-1]) ||
                                (is_shift && dp.sh_lost));
    end
  end

  // Per-accumulator state: contents and status flags
  for (genvar g = 0; g < 2; g++) begin : g_acc
    logic op_hit;
    logic mm_hit;
    assign op_hit = write_nxt && (acc_sel_i == 1'(g));
    assign mm_hit = mm_wr_i && (mm_acc_i == 1'(g));

    // Contents; a datapath op wins over a mapped write
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        acc_r[g] <= `AOED_ACC_RST;
      end else if (op_hit) begin
        acc_r[g] <= result_nxt;
      end else if (mm_hit) begin
        case (mm_part_i)
          AOED_PART_LOW: acc_r[g][`AOED_LOW_MSB:`AOED_LOW_LSB] <= mm_wdata_i;
          AOED_PART_HIGH: acc_r[g][`AOED_HIGH_MSB:`AOED_HIGH_LSB] <= mm_wdata_i;
          AOED_PART_GUARD: begin
            acc_r[g][`AOED_GUARD_MSB:`AOED_GUARD_LSB] <= mm_wdata_i[`AOED_GUARD_W-1:0];
          end
          default: acc_r[g] <= acc_r[g];
        endcase
      end
    end

    // Overflow into guard bits, updated only by datapath ops
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        ovf_r[g] <= 1'b0;
      end else if (op_hit) begin
        ovf_r[g] <= !((&result_nxt[`AOED_GUARD_MSB:`AOED_SIGN31_BIT]) ||
                      !(|result_nxt[`AOED_GUARD_MSB:`AOED_SIGN31_BIT]));
      end
    end

    // Sticky 40-bit wrap flag; a new event beats a clear
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        sat_r[g] <= 1'b0;
      end else if (op_hit && sat_event) begin
        sat_r[g] <= 1'b1;
      end else if (clear_sat_i) begin
        sat_r[g] <= 1'b0;
      end
    end
  end

  // Store port: plain high word or rounded 1.15 word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      store_data_o <= `AOED_WORD_RST;
      store_valid_o <= 1'b0;
    end else begin
      store_valid_o <= 1'b0;
      if (op_valid_i && (op_i == AOED_OP_STORE)) begin
        store_data_o <= sel_acc[`AOED_HIGH_MSB:`AOED_HIGH_LSB];
        store_valid_o <= 1'b1;
      end else if (op_valid_i && (op_i == AOED_OP_STORE_RND)) begin
        store_data_o <= round_sum[`AOED_HIGH_MSB:`AOED_HIGH_LSB];
        store_valid_o <= 1'b1;
      end
    end
  end

  // Exponent result register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exp_result_o <= `AOED_EXP_RST;
      exp_valid_o <= 1'b0;
    end else begin
      exp_valid_o <= op_valid_i && (op_i == AOED_OP_EXP_FIND);
      if (op_valid_i && (op_i == AOED_OP_EXP_FIND)) begin
        exp_result_o <= dp.ex_result;
      end
    end
  end

  // Mapped read, guard byte sign-extended to a word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mm_rdata_o <= `AOED_WORD_RST;
    end else begin
      case (mm_part_i)
        AOED_PART_LOW: mm_rdata_o <= acc_r[mm_acc_i][`AOED_LOW_MSB:`AOED_LOW_LSB];
        AOED_PART_HIGH: mm_rdata_o <= acc_r[mm_acc_i][`AOED_HIGH_MSB:`AOED_HIGH_LSB];
        AOED_PART_GUARD: begin
          mm_rdata_o <= {{(`AOED_WORD_W - `AOED_GUARD_W){acc_r[mm_acc_i][`AOED_GUARD_MSB]}},
                         acc_r[mm_acc_i][`AOED_GUARD_MSB:`AOED_GUARD_LSB]};
        end
        default: mm_rdata_o <= `AOED_WORD_RST;
      endcase
    end
  end

  // Registered status and contents out
  assign accum_a_overflow_flag_o = ovf_r[0];
  assign accum_b_overflow_flag_o = ovf_r[1];
  assign accum_a_sat_flag_o = sat_r[0];
  assign accum_b_sat_flag_o = sat_r[1];
  assign acc_a_o = acc_r[0];
  assign acc_b_o = acc_r[1];
endmodule

`default_nettype wire

// *** aoed_checker.sv ***
// Checker on the accumulator datapath top ports.
// Assumes a bind onto aoed_top from the testbench file.
`timescale 1ns/10ps
`default_nettype none
`include "aoed_defs.svh"
module aoed_checker import aoed_pkg::*; (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire aoed_pkg::aoed_op_t op_i,
  input wire logic acc_sel_i,
  input wire logic [15:0] operand_i,
  input wire logic exp_byte_i,
  input wire logic [15:0] store_data_o,
  input wire logic store_valid_o,
  input wire logic [5:0] exp_result_o,
  input wire logic exp_valid_o,
  input wire logic accum_a_overflow_flag_o,
  input wire logic [39:0] acc_a_o,
  input wire logic [39:0] acc_b_o
);
  logic [39:0] sel_acc, rnd_sum, sum_ab, neg_a, ld_val;
  logic [15:0] hi_w, rnd_hi;
  // Expected values from current contents
  assign sel_acc = acc_sel_i ? acc_b_o : acc_a_o;
  assign rnd_sum = sel_acc + 40'h00_0000_8000;
  assign hi_w = sel_acc[31:16];
  assign rnd_hi = rnd_sum[31:16];
  assign sum_ab = acc_a_o + acc_b_o;
  assign neg_a = 40'h00_0000_0000 - acc_a_o;
  assign ld_val = {{8{operand_i[15]}}, operand_i, 16'h0000};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_STORE: assert property (op_valid_i && op_i == AOED_OP_STORE |=>
    store_valid_o && store_data_o == $past(hi_w)) else $error("store word wrong");
  AST_RND: assert property (op_valid_i && op_i == AOED_OP_STORE_RND |=>
    store_valid_o && store_data_o == $past(rnd_hi)) else $error("rounded store wrong");
  AST_QUIET: assert property (!op_valid_i |=> !store_valid_o && !exp_valid_o)
    else $error("result pulse without op");
  AST_ADD: assert property (op_valid_i && op_i == AOED_OP_ADD_ACC && !acc_sel_i |=>
    acc_a_o == $past(sum_ab)) else $error("accumulator sum wrong");
  AST_LOAD: assert property (op_valid_i && op_i == AOED_OP_LOAD && !acc_sel_i |=>
    acc_a_o == $past(ld_val)) else $error("load wrong");
  AST_NEG: assert property (op_valid_i && op_i == AOED_OP_NEGATE && !acc_sel_i |=>
    acc_a_o == $past(neg_a)) else $error("negate wrong");
  AST_EXP_RANGE: assert property (exp_valid_o |->
    exp_result_o == 6'h00 || exp_result_o >= 6'h31) else $error("exponent out of range");
  AST_EXP_FULL: assert property (op_valid_i && op_i == AOED_OP_EXP_FIND && !exp_byte_i &&
    operand_i[15] != operand_i[14] |=> exp_valid_o && exp_result_o == 6'h00)
    else $error("full scale exponent wrong");
  AST_EXP_FLAT: assert property (op_valid_i && op_i == AOED_OP_EXP_FIND && !exp_byte_i &&
    (operand_i == 16'h0000 || operand_i == 16'hffff) |=> exp_result_o == 6'h31)
    else $error("flat word exponent wrong");
  AST_FLAG: assert property (!op_valid_i |=> $stable(accum_a_overflow_flag_o))
    else $error("flag moved without op");
endmodule
`default_nettype wire

// *** aoed_mem_model.sv ***
// Data memory stand-in taking the datapath's store words.
// Assumes at most one store pulse per core clock.
`timescale 1ns/10ps
`default_nettype none
module aoed_mem_model (
  // Clock
  input wire logic clk_i,
  // Store port
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  // Last stored word
  output logic [15:0] word_o
);
  // Capture a word on each store pulse
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      word_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for aoed_top against a reference model.
// Assumes the checker and memory stand-in are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import aoed_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, acc_sel_i = 1'b0, exp_byte_i = 1'b0;
  logic mm_wr_i = 1'b0, mm_acc_i = 1'b0, clear_sat_i = 1'b0, sv, ova, ovb, sa, sb;
  logic moa = 1'b0, mob = 1'b0, msa = 1'b0, msb = 1'b0;
  aoed_op_t op_i = AOED_OP_NOP;
  aoed_part_t mm_part_i = AOED_PART_LOW;
  logic [5:0] lit_shift_i = '0, exp_result_o, me;
  logic [15:0] reg_shift_i = '0, operand_i = '0, mm_wdata_i = '0, store_data_o, mm_rdata_o;
  logic [15:0] mem_word, sd;
  logic store_valid_o, exp_valid_o;
  logic [39:0] acc_a_o, acc_b_o, ma, mb;
  logic [31:0] rs = 32'h0001_8605;
  logic [15:0] tbl [15] = '{16'h0001, 16'h0002, 16'h0004, 16'h0100, 16'h01ff, 16'h0806,
    16'h2007, 16'h4800, 16'h7000, 16'h8000, 16'h900a, 16'he001, 16'hff07, 16'h0000, 16'hffff};
  int err_count = 0, comparisons = 0, cyc = 0;
  aoed_top aoed_top_i (.clk_i, .rst_i, .op_valid_i, .op_i, .acc_sel_i, .lit_shift_i,
    .reg_shift_i, .operand_i, .exp_byte_i, .store_data_o, .store_valid_o, .exp_result_o,
    .exp_valid_o, .mm_wr_i, .mm_acc_i, .mm_part_i, .mm_wdata_i, .mm_rdata_o, .clear_sat_i,
    .accum_a_overflow_flag_o(ova), .accum_b_overflow_flag_o(ovb), .accum_a_sat_flag_o(sa),
    .accum_b_sat_flag_o(sb), .acc_a_o, .acc_b_o);
  aoed_mem_model aoed_mem_model_i (.clk_i, .wr_i(store_valid_o), .wdata_i(store_data_o),
    .word_o(mem_word));
  // Clock and cycle ceiling
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk40(logic [39:0] got, logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk16(logic [15:0] got, logic [15:0] exp);
    chk40({24'h000000, got}, {24'h000000, exp});
  endtask
  // One decoder op through model and design
  task automatic step(aoed_op_t op, logic sel, logic [15:0] d, logic [5:0] lt,
      logic [15:0] rg, logic b);
    logic [39:0] t;
    logic signed [5:0] sh;
    int s, n;
    logic ev;
    logic signed [40:0] x;
    logic wr, lost, ov;
    t = sel ? mb : ma;
    sv = 1'b0;
    ev = 1'b0;
    n = 0;
    lost = 1'b0;
    x = $signed(t);
    wr = op inside {AOED_OP_ADD_ACC, AOED_OP_SUB_ACC, AOED_OP_ADD_W16, AOED_OP_LOAD,
      AOED_OP_NEGATE, AOED_OP_SHIFT_LIT, AOED_OP_SHIFT_REG};
    sh = (op == AOED_OP_SHIFT_REG) ? rg[5:0] : lt;
    s = sh;
    case (op)
      AOED_OP_ADD_ACC: x = $signed(ma) + $signed(mb);
      AOED_OP_SUB_ACC: x = sel ? $signed(mb) - $signed(ma) : $signed(ma) - $signed(mb);
      AOED_OP_ADD_W16: x = $signed(t) + $signed(d);
      AOED_OP_LOAD: x = $signed({d, 16'h0000});
      AOED_OP_NEGATE: x = -$signed(t);
      AOED_OP_STORE: begin
        sv = 1'b1;
        sd = t[31:16];
      end
      AOED_OP_STORE_RND: begin
        sv = 1'b1;
        sd = 16'((t + 40'h00_0000_8000) >> 16);
      end
      AOED_OP_SHIFT_LIT, AOED_OP_SHIFT_REG: begin
        if (s < 0) t = t << -s;
        else t = $signed(t) >>> s;
        lost = (s < 0) && (($signed(t) >>> -s) != x);
        x = $signed(t);
      end
      AOED_OP_EXP_FIND: begin
        ev = 1'b1;
        for (int i = b ? 6 : 14; i >= 0 && d[i] == d[b ? 7 : 15]; i--) n++;
        me = 6'(-n);
      end
      default: ;
    endcase
    // Written value, overflow and sticky wrap flags
    t = x[39:0];
    ov = !(&t[39:31] || !(|t[39:31]));
    lost = lost || (x[40] != x[39]);
    if (wr && sel) {mob, msb} = {ov, msb | lost};
    if (wr && !sel) {moa, msa} = {ov, msa | lost};
    if (sel) mb = t;
    else ma = t;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    acc_sel_i <= sel;
    operand_i <= d;
    lit_shift_i <= lt;
    reg_shift_i <= rg;
    exp_byte_i <= b;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    chk40(acc_a_o, ma);
    chk40(acc_b_o, mb);
    chk16({15'h0000, store_valid_o}, {15'h0000, sv});
    if (sv) chk16(store_data_o, sd);
    if (ev) chk16({10'h000, exp_result_o}, {10'h000, me});
    chk16({15'h0000, exp_valid_o}, {15'h0000, ev});
    chk16({12'h000, ova, ovb, sa, sb}, {12'h000, moa, mob, msa, msb});
    @(posedge clk_i);
    #1;
    if (sv) chk16(mem_word, sd);
  endtask
  // One mapped access, write or read
  task automatic mm(logic a, aoed_part_t p, logic [15:0] w, logic wr);
    logic [39:0] t;
    t = a ? mb : ma;
    @(posedge clk_i);
    mm_wr_i <= wr;
    mm_acc_i <= a;
    mm_part_i <= p;
    mm_wdata_i <= w;
    @(posedge clk_i);
    mm_wr_i <= 1'b0;
    #1;
    if (!wr) chk16(mm_rdata_o, p == AOED_PART_GUARD ? {{8{t[39]}}, t[39:32]} :
      p == AOED_PART_HIGH ? t[31:16] : p == AOED_PART_LOW ? t[15:0] : 16'h0000);
    if (wr && p == AOED_PART_HIGH) t[31:16] = w;
    if (wr && p == AOED_PART_LOW) t[15:0] = w;
    if (wr && p == AOED_PART_GUARD) t[39:32] = w[7:0];
    if (a) mb = t;
    else ma = t;
  endtask
  // Clear pulse on the sticky wrap flags
  task automatic clr();
    @(posedge clk_i);
    clear_sat_i <= 1'b1;
    @(posedge clk_i);
    clear_sat_i <= 1'b0;
    #1;
    msa = 1'b0;
    msb = 1'b0;
    chk16({12'h000, ova, ovb, sa, sb}, {12'h000, moa, mob, msa, msb});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    ma = '0;
    mb = '0;
    @(posedge clk_i);
    #1;
    chk40(acc_a_o, 40'h00_0000_0000);
    foreach (tbl[k]) step(AOED_OP_EXP_FIND, 1'b0, tbl[k], 6'h00, 16'h0000, 1'b0);
    step(AOED_OP_LOAD, 1'b0, 16'h8001, 6'h00, 16'h0000, 1'b0);
    step(AOED_OP_SHIFT_LIT, 1'b0, 16'h0000, 6'h04, 16'h0000, 1'b0);
    step(AOED_OP_SHIFT_REG, 1'b0, 16'h0000, 6'h00, 16'hfffc, 1'b0);
    mm(1'b0, AOED_PART_GUARD, 16'h0000, 1'b0);
    repeat (400) begin
      rs = xs(rs);
      step(aoed_op_t'(4'(rs[7:0] % 8'h0b)), rs[8], rs[31:16], rs[14:9], rs[30:15], rs[21]);
      if (rs[3:1] == 3'h0) mm(rs[22], aoed_part_t'(rs[24:23]), rs[31:16], rs[25]);
      if (rs[6:4] == 3'h0) clr();
    end
    report_and_stop();
  end
endmodule
bind aoed_top aoed_checker aoed_checker_i (.clk_i, .rst_i, .op_valid_i, .op_i, .acc_sel_i,
  .operand_i, .exp_byte_i, .store_data_o, .store_valid_o, .exp_result_o, .exp_valid_o,
  .accum_a_overflow_flag_o, .acc_a_o, .acc_b_o);
`default_nettype wire
